/* rtl/validated_digital_output.v */
// validated digital output channel with ahb-lite register slave
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module validated_digital_output
(
    // clock and reset
    input  wire        i_mclk,
    input  wire        i_srst,
    // ahb-lite slave
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output wire        o_hreadyout,
    output wire        o_hresp,
    // physical output module side
    input  wire        i_module_error,
    output reg         o_phys_out,
    output reg         o_channel_enable,
    // feedback input module side
    input  wire        i_feedback_raw,
    input  wire        i_feedback_module_error,
    // block pins
    input  wire        i_latch_release_in,
    input  wire        i_channel_disable_in,
    output reg         o_fail,
    output reg         o_feedback_module_error,
    output reg         o_readback_mismatch,
    // scan tick, for observation
    output wire        o_scan_tick
);
`include "dov_regs.vh"

    // ****************************************************************
    // declarations
    // ****************************************************************
    reg  [`CTRL_WIDTH-1:0] ctrl;        // software configuration
    reg  [31:0]            addr_cfg;    // output and feedback addresses
    reg                    out_val;     // block output value (pre-invert)
    reg                    hold_val;    // last good value for hold
    reg                    latched;     // failure latched state
    reg                    release_q;   // previous-tick release sample
    reg                    wr_pend;     // write data phase pending
    reg                    rd_pend;     // read data phase pending
    reg  [7:0]             ph_addr;     // captured address phase offset
    wire                   tick;        // scan tick strobe
    wire                   addr_ok;     // output address in range
    wire                   fb_addr_ok;  // feedback address in range
    wire                   rel_edge;    // release rising edge this tick
    wire                   fail_now;    // failure state after this tick
    wire                   disabled;    // channel disabled
    wire                   fb_val;      // readback after feedback invert
    wire                   written;     // value written to pin
    reg                    next_out;    // next block output value
    wire                   take;        // address phase accepted

    // ****************************************************************
    // helpers
    // ****************************************************************
    // decode failsafe choice into a value; safety mode always off
    function fs_value;
        input [1:0] choice;
        input       safety;
        input       held;
        begin
            if (safety)
                fs_value = 1'b0;
            else
            begin
                case (choice)
                    `FS_ON:   fs_value = 1'b1;
                    `FS_HOLD: fs_value = held;
                    default:  fs_value = 1'b0;
                endcase
            end
        end
    endfunction

    // ****************************************************************
    // sub blocks
    // ****************************************************************
    scan_ticker u_tick
    (
        .i_mclk (i_mclk),
        .i_srst (i_srst),
        .o_tick (tick)
    );

    // output channel address check
    addr_check u_addr
    (
        .i_rack    (addr_cfg[`AD_RACK_MSB:`AD_RACK_LSB]),
        .i_module  (addr_cfg[`AD_MOD_MSB:`AD_MOD_LSB]),
        .i_channel (addr_cfg[`AD_CH_MSB:`AD_CH_LSB]),
        .o_ok      (addr_ok)
    );

    // feedback channel address check
    addr_check u_fb_addr
    (
        .i_rack    (addr_cfg[`AD_FB_RACK_MSB:`AD_FB_RACK_LSB]),
        .i_module  (addr_cfg[`AD_FB_MOD_MSB:`AD_FB_MOD_LSB]),
        .i_channel (addr_cfg[`AD_FB_CH_MSB:`AD_FB_CH_LSB]),
        .o_ok      (fb_addr_ok)
    );

    assign o_scan_tick = tick;

    // ****************************************************************
    // channel decisions
    // ****************************************************************
    // disable pin only counts when marked connected
    assign disabled = ctrl[`CTRL_DIS_CONN] & i_channel_disable_in;
    // release edge found against previous tick sample, masked by disable
    assign rel_edge = i_latch_release_in & ~release_q
                      & ~disabled;
    // latched: stays set until release edge clears it and error is gone
    assign fail_now = ctrl[`CTRL_REL_CONN]
                      ? (i_module_error | (latched & ~rel_edge))
                      : i_module_error;
    assign fb_val   = i_feedback_raw ^ ctrl[`CTRL_FB_INV];
    assign written  = o_phys_out;

    // output value: normal follows x, failure takes failsafe
    always @*
    begin
        if (fail_now)
            next_out = fs_value(ctrl[`CTRL_FS_MSB:`CTRL_FS_LSB],
                                ctrl[`CTRL_SAFETY], hold_val);
        else
            next_out = ctrl[`CTRL_X];
    end

    // ****************************************************************
    // scan-rate evaluation
    // ****************************************************************
    // all pins and flags change only on tick, so a scan sees one view
    always @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            out_val                 <= 1'b0;
            hold_val                <= 1'b0;
            latched                 <= 1'b0;
            release_q               <= 1'b0;
            o_phys_out              <= 1'b0;
            o_channel_enable        <= 1'b0;
            o_fail                  <= 1'b0;
            o_feedback_module_error <= 1'b0;
            o_readback_mismatch     <= 1'b0;
        end
        else if (tick)
        begin
            release_q <= i_latch_release_in;
            latched   <= ctrl[`CTRL_REL_CONN] & fail_now;
            o_fail    <= fail_now;
            out_val   <= next_out;
            // hold keeps the value just before failure
            if (!fail_now)
                hold_val <= ctrl[`CTRL_X];
            // bad address or disable: channel stays off
            o_channel_enable <= addr_ok & ~disabled;
            if (disabled || !addr_ok)
                o_phys_out <= 1'b0;
            else
                o_phys_out <= next_out ^ ctrl[`CTRL_OUT_INV];
            // validation only in the validated variant
            if (ctrl[`CTRL_VALID] && fb_addr_ok)
            begin
                o_feedback_module_error <= i_feedback_module_error;
                // compare against what was driven last scan
                o_readback_mismatch <= ~i_feedback_module_error
                                       & ~disabled
                                       & (fb_val != written);
            end
            else
            begin
                o_feedback_module_error <= 1'b0;
                o_readback_mismatch     <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // ahb-lite slave: zero wait states, always okay
    // ****************************************************************
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign take        = i_hsel & i_hready & i_htrans[1];

    // address phase capture
    always @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (i_hready)
        begin
            wr_pend <= take & i_hwrite;
            rd_pend <= take & ~i_hwrite;
            ph_addr <= i_haddr[`OFS_ADDR_MSB:`OFS_ADDR_LSB];
        end
    end

    // data phase writes; unmapped offsets ignored
    always @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            ctrl     <= `CTRL_RESET;
            addr_cfg <= `ADDR_RESET;
        end
        else if (wr_pend)
        begin
            case (ph_addr)
                `OFS_CTRL: ctrl     <= i_hwdata[`CTRL_WIDTH-1:0];
                `OFS_ADDR: addr_cfg <= i_hwdata;
                default:   ;
            endcase
        end
    end

    // read data registered at the address phase for zero-wait reply
    always @(posedge i_mclk)
    begin
        if (i_srst)
            o_hrdata <= 32'h0000_0000;
        else if (take && !i_hwrite)
        begin
            case (i_haddr[`OFS_ADDR_MSB:`OFS_ADDR_LSB])
                `OFS_CTRL:   o_hrdata <= {23'h00_0000, ctrl};
                `OFS_ADDR:   o_hrdata <= addr_cfg;
                `OFS_STATUS: o_hrdata <= {26'h000_0000, addr_ok,
                                          latched,
                                          o_readback_mismatch,
                                          o_feedback_module_error,
                                          o_fail, out_val};
                `OFS_INPUT:  o_hrdata <= {28'h000_0000,
                                          i_channel_disable_in,
                                          i_latch_release_in,
                                          i_feedback_module_error,
                                          i_feedback_raw};
                default:     o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // validated_digital_output

/* rtl/dov_regs.vh */
// register map, field positions, reset values and encodings for the output
`ifndef DOV_REGS_VH
`define DOV_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL       8'h00
`define OFS_ADDR       8'h04
`define OFS_STATUS     8'h08
`define OFS_INPUT      8'h0C
`define OFS_ADDR_MSB   7
`define OFS_ADDR_LSB   0

// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_X         0
`define CTRL_OUT_INV   1
`define CTRL_FB_INV    2
`define CTRL_FS_LSB    3
`define CTRL_FS_MSB    4
`define CTRL_SAFETY    5
`define CTRL_VALID     6
`define CTRL_REL_CONN  7
`define CTRL_DIS_CONN  8
`define CTRL_WIDTH     9
`define CTRL_RESET     9'h000

// failsafe choice encodings
`define FS_OFF         2'h0
`define FS_ON          2'h1
`define FS_HOLD        2'h2

// ****************************************************************
// address register fields: rack, module, channel, and feedback copy
// ****************************************************************
`define AD_RACK_LSB    0
`define AD_RACK_MSB    3
`define AD_MOD_LSB     4
`define AD_MOD_MSB     7
`define AD_CH_LSB      8
`define AD_CH_MSB      13
`define AD_FB_RACK_LSB 16
`define AD_FB_RACK_MSB 19
`define AD_FB_MOD_LSB  20
`define AD_FB_MOD_MSB  23
`define AD_FB_CH_LSB   24
`define AD_FB_CH_MSB   29
`define ADDR_RESET     32'h0101_0101
`define RACK_MIN       4'h1
`define RACK_MAX       4'hC
`define MOD_MIN        4'h1
`define MOD_MAX        4'hC
`define CH_MIN         6'h01
`define CH_MAX         6'h20

// ****************************************************************
// status register fields
// ****************************************************************
`define ST_OUT         0
`define ST_FAIL        1
`define ST_FEEDBACK_MODULE_ERROR      2
`define ST_MISMATCH    3
`define ST_LATCHED     4
`define ST_ADDR_OK     5
`define ST_WIDTH       6

// ****************************************************************
// scan tick period in clock cycles (evaluation rate)
// ****************************************************************
`define SCAN_CYCLES    16'h0010
`define SCAN_RESET     16'h0000

`endif

/* rtl/scan_ticker.v */
// scan tick generator: one pulse every scan period
`timescale 1ns/1ps
module scan_ticker
(
    // clock and reset
    input  wire        i_mclk,
    input  wire        i_srst,
    // tick out
    output wire        o_tick
);
`include "dov_regs.vh"

    reg [15:0] count;   // cycles since last tick

    // ****************************************************************
    // free running divider
    // ****************************************************************
    always @(posedge i_mclk)
    begin
        if (i_srst || count == `SCAN_CYCLES - 16'h0001)
            count <= `SCAN_RESET;
        else
            count <= count + 16'h0001;
    end

    // combinational handshake-like strobe, one cycle wide
    assign o_tick = (count == `SCAN_CYCLES - 16'h0001);

endmodule // scan_ticker

/* rtl/addr_check.v */
// range check of one rack/module/channel address triple
`timescale 1ns/1ps
module addr_check
(
    // address fields
    input  wire [3:0]  i_rack,
    input  wire [3:0]  i_module,
    input  wire [5:0]  i_channel,
    // verdict
    output wire        o_ok
);
`include "dov_regs.vh"

    // ****************************************************************
    // rack and module 1..12, channel 1..32
    // ****************************************************************
    assign o_ok = (i_rack    >= `RACK_MIN) && (i_rack    <= `RACK_MAX) &&
                  (i_module  >= `MOD_MIN)  && (i_module  <= `MOD_MAX)  &&
                  (i_channel >= `CH_MIN)   && (i_channel <= `CH_MAX);

endmodule // addr_check

/* dv/validated_digital_output_chk.sv */
// assertion checker for the validated digital output block
`timescale 1ns/1ps
module validated_digital_output_chk
(
    // clock and reset
    input wire        i_mclk,
    input wire        i_srst,
    // bus
    input wire        i_hsel,
    input wire [1:0]  i_htrans,
    input wire        i_hwrite,
    input wire        i_hready,
    input wire [31:0] o_hrdata,
    input wire        o_hreadyout,
    input wire        o_hresp,
    // channel
    input wire        i_module_error,
    input wire        i_feedback_module_error,
    input wire        o_phys_out,
    input wire        o_channel_enable,
    input wire        o_fail,
    input wire        o_feedback_module_error,
    input wire        o_readback_mismatch,
    input wire        o_scan_tick
);
    // ****************************************************************
    // helpers and sequences
    // ****************************************************************
    wire rd_take = i_hsel & i_hready & i_htrans[1] & ~i_hwrite; // read taken
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    sequence s_quiet;   // a cycle after a reset-free, tick-free cycle
        !$past(o_scan_tick) && !$past(i_srst);
    endsequence
    sequence s_gap;     // tick then a run of silence
        o_scan_tick ##1 !o_scan_tick [*8];
    endsequence
    // ****************************************************************
    // assertions
    // ****************************************************************
    a_tick_period: assert property (o_scan_tick |-> ##16 o_scan_tick)
        else $error("scan tick period wrong");
    a_tick_gap: assert property (o_scan_tick |-> s_gap)
        else $error("scan tick repeated too soon");
    a_out_hold: assert property (s_quiet |-> $stable(o_phys_out)
        && $stable(o_channel_enable)) else $error("output moved off tick");
    a_flag_hold: assert property (s_quiet |-> $stable(o_fail)
        && $stable(o_feedback_module_error) && $stable(o_readback_mismatch))
        else $error("flag moved off tick");
    a_fail_cause: assert property ($rose(o_fail) |->
        $past(i_module_error) && $past(o_scan_tick))
        else $error("fail rose without module error");
    a_feedback_module_error_cause: assert property ($rose(o_feedback_module_error)
        |-> $past(i_feedback_module_error))
        else $error("feedback fail rose without cause");
    a_mismatch_off: assert property ($past(o_scan_tick) && !$past(i_srst)
        && $past(i_feedback_module_error) |-> !o_readback_mismatch)
        else $error("mismatch set during feedback error");
    a_rdata_hold: assert property (!$past(rd_take) && !$past(i_srst)
        |-> $stable(o_hrdata)) else $error("read data moved");
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus not ready or not okay");
endmodule // validated_digital_output_chk

bind validated_digital_output validated_digital_output_chk u_chk
(
    .i_mclk, .i_srst, .i_hsel, .i_htrans, .i_hwrite, .i_hready, .o_hrdata,
    .o_hreadyout, .o_hresp, .i_module_error, .i_feedback_module_error,
    .o_phys_out, .o_channel_enable, .o_fail, .o_feedback_module_error,
    .o_readback_mismatch, .o_scan_tick
);

/* dv/dout_field_model.sv */
// far-side model: physical output module and feedback input module
`timescale 1ns/1ps
module dout_field_model
(
    // clock
    input  wire logic i_mclk,
    // bench commands
    input  wire logic i_break_out,  // output module fault
    input  wire logic i_break_fb,   // feedback module fault
    input  wire logic i_wire_flip,  // feedback wiring inverted
    // block side
    input  wire logic i_phys_out,
    input  wire logic i_channel_enable,
    output logic      o_module_error = 1'h0,
    output logic      o_feedback_raw = 1'h0,
    output logic      o_feedback_module_error = 1'h0
);
    logic coil = 1'h0; // coil state, de-energised while disabled
    // modules answer one cycle late, like a real i/o scan
    always @(posedge i_mclk)
    begin
        coil <= i_phys_out & i_channel_enable;
        o_module_error <= i_break_out;
        o_feedback_module_error <= i_break_fb;
        // a dead feedback module toggles rather than holding its last value
        o_feedback_raw <= i_break_fb ? ~o_feedback_raw : coil ^ i_wire_flip;
    end
endmodule // dout_field_model

/* dv/validated_digital_output_tb.sv */
// self-checking bench for the validated digital output block
`timescale 1ns/1ps
`include "dov_regs.vh"
module validated_digital_output_tb;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic        i_mclk = 1'h0;
    logic        i_srst = 1'h1;
    logic [31:0] haddr  = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic        brk_out = 1'h0, brk_fb = 1'h0, flip = 1'h0;
    logic        rel = 1'h0, dis = 1'h0, x;
    wire  [31:0] hrdata;
    wire         hrdy, hresp, phys, en, fail, fbf, mism, tick;
    wire         merr, fbraw, fberr;
    int          err_total = 0, n_compared = 0, cyc = 0;
    logic [31:0] seed = 32'h0000_d5d1, rd;

    always #2 i_mclk = ~i_mclk;  // 250 MHz
    validated_digital_output DUT (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_hsel(1'h1), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
        .o_hreadyout(hrdy), .o_hresp(hresp), .i_module_error(merr),
        .o_phys_out(phys), .o_channel_enable(en), .i_feedback_raw(fbraw),
        .i_feedback_module_error(fberr), .i_latch_release_in(rel),
        .i_channel_disable_in(dis), .o_fail(fail),
        .o_feedback_module_error(fbf), .o_readback_mismatch(mism),
        .o_scan_tick(tick));
    dout_field_model u_field (.i_mclk(i_mclk), .i_break_out(brk_out),
        .i_break_fb(brk_fb), .i_wire_flip(flip), .i_phys_out(phys),
        .i_channel_enable(en), .o_module_error(merr),
        .o_feedback_raw(fbraw), .o_feedback_module_error(fberr));

    // ****************************************************************
    // tasks and functions
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // failsafe value: safety mode always forces off
    function automatic logic fs_exp(input int f, input logic s, input logic v);
        if (s) return 1'h0;
        return (f == 2) ? v : f[0];
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one single ahb-lite transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge i_mclk); while (hrdy !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_mclk); while (hrdy !== 1'h1);
        rd = hrdata;
    endtask
    // three ticks: input sampled, field loop settled, readback compared
    task automatic settle();
        repeat (3) do @(posedge i_mclk); while (tick !== 1'h1);
        @(posedge i_mclk);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            err_total++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (16) @(posedge i_mclk);
        i_srst <= 1'h0;
        bus(1'h0, `OFS_ADDR, 32'h0000_0000);
        chk_word(rd, `ADDR_RESET);
        bus(1'h0, 32'h0000_0010, 32'h0000_0000); // unmapped reads zero
        chk_word(rd, 32'h0000_0000);
        // reset address has module 0: out of range, channel held off
        settle();
        chk_bit(en, 1'h0);
        bus(1'h0, `OFS_STATUS, 32'h0000_0000);
        chk_bit(rd[`ST_ADDR_OK], 1'h0);
        // channel 33 is one past the top, still refused
        bus(1'h1, `OFS_ADDR, 32'h0111_2111);
        settle();
        chk_bit(en, 1'h0);
        // top channel 32 on rack 1 module 1, feedback on rack 1 module 1
        bus(1'h1, `OFS_ADDR, 32'h0111_2011);
        bus(1'h0, `OFS_ADDR, 32'h0000_0000);
        chk_word(rd, 32'h0111_2011);
        // random input status and inversion
        repeat (6)
        begin
            seed = lfsr(seed);
            bus(1'h1, `OFS_CTRL, {30'h0, seed[1:0]});
            settle();
            chk_bit(phys, seed[0] ^ seed[1]);
            chk_bit(en, 1'h1);
            bus(1'h0, `OFS_STATUS, 32'h0000_0000);
            chk_bit(rd[`ST_OUT], seed[0]);
        end
        // every failsafe choice in both modes, input flipped mid-failure
        for (int k = 0; k < 6; k++)
        begin
            seed = lfsr(seed);
            x = seed[0];
            bus(1'h1, `OFS_CTRL, {26'h0, k[0], k[2:1], 2'h0, x});
            settle();
            brk_out <= 1'h1;
            settle();
            bus(1'h1, `OFS_CTRL, {26'h0, k[0], k[2:1], 2'h0, ~x});
            settle();
            chk_bit(fail, 1'h1);
            chk_bit(phys, fs_exp(k / 2, k[0], x));
            brk_out <= 1'h0;
            settle();
            chk_bit(fail, 1'h0);
            chk_bit(phys, ~x);
        end
        // latched failure, release ignored while disabled
        bus(1'h1, `OFS_CTRL, 32'h0000_0181);
        brk_out <= 1'h1;
        settle();
        brk_out <= 1'h0;
        settle();
        chk_bit(fail, 1'h1);
        dis <= 1'h1;
        rel <= 1'h1;
        settle();
        chk_bit(en, 1'h0);
        chk_bit(fail, 1'h1);
        rel <= 1'h0;
        dis <= 1'h0;
        settle();
        chk_bit(en, 1'h1);
        chk_bit(phys, 1'h0);
        rel <= 1'h1;
        settle();
        chk_bit(fail, 1'h0);
        chk_bit(phys, 1'h1);
        rel <= 1'h0;
        // readback validation over wiring and feedback inversion
        for (int j = 0; j < 4; j++)
        begin
            seed = lfsr(seed);
            flip <= j[1];
            bus(1'h1, `OFS_CTRL, {25'h0, 1'h1, 3'h0, j[0], 1'h0, seed[0]});
            settle();
            chk_bit(mism, j[1] ^ j[0]);
            chk_bit(phys, seed[0]);
            brk_fb <= 1'h1;
            settle();
            chk_bit(fbf, 1'h1);
            chk_bit(mism, 1'h0);
            chk_bit(phys, seed[0]);
            brk_fb <= 1'h0;
            settle();
            chk_bit(fbf, 1'h0);
        end
        flip <= 1'h0;
        give_verdict();
    end
endmodule // validated_digital_output_tb
